/* File: hw/timer_event_map.vh */
`ifndef TIMER_EVENT_MAP_VH
`define TIMER_EVENT_MAP_VH

// Register bus geometry
`define ADDR_W            8
`define DATA_W            32
`define STRB_FULL         4'hF

// Register byte offsets
`define OFS_CONTROL       8'h00
`define OFS_CHAN_MODE     8'h04
`define OFS_DMA_ENABLE    8'h08
`define OFS_INT_ENABLE    8'h0C
`define OFS_FLAGS         8'h10
`define OFS_SW_EVENT      8'h14
`define OFS_FLAG_CLEAR    8'h18

// Event bit positions, shared by request, flag and enable layouts
`define EV_W              8
`define EV_UPDATE         0
`define EV_CH0            1
`define EV_CH3            4
`define EV_COMMUTATION    5
`define EV_TRIGGER        6
`define EV_BREAK          7

// Control register fields
`define CTL_PRIMARY_OUTPUT_ENABLE          0
`define CHAN_W            4

// Reset values
`define RST_SW_EVENT      8'h00
`define RST_FLAGS         8'h00
`define RST_ENABLES       8'h00
`define RST_CHAN_MODE     4'h0
`define RST_PRIMARY_OUTPUT_ENABLE          1'b0

// Bus responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

/* File: hw/event_flag_bank.v */
`timescale 1ns/100ps
`include "timer_event_map.vh"

// Sticky event flags: hardware sets, software clears, set wins
module event_flag_bank
(
   input  wire                  sys_clk_in,
   input  wire                  rst_in,
   input  wire [`EV_W-1:0]      set_in,
   input  wire [`EV_W-1:0]      clear_in,
   output wire [`EV_W-1:0]      flag_out,
   output wire [`EV_W-1:0]      flag_nxt_out
);

   reg  [`EV_W-1:0] flag_r;
   wire [`EV_W-1:0] flag_nxt;

   genvar i;
   generate
      for (i = 0; i < `EV_W; i = i + 1)
      begin : g_flag
         // Set term is ORed last so a same-cycle clear cannot lose it
         assign flag_nxt[i] = set_in[i] | (flag_r[i] & ~clear_in[i]);

         always @(posedge sys_clk_in or posedge rst_in)
         begin
            if (rst_in)
               flag_r[i] <= 1'b0;
            else
               flag_r[i] <= flag_nxt[i];
         end
      end
   endgenerate

   assign flag_out     = flag_r;
   assign flag_nxt_out = flag_nxt;

endmodule // event_flag_bank

/* File: hw/axil_reg_port.v */
`timescale 1ns/100ps
`include "timer_event_map.vh"

// AXI4-Lite slave front end: one write and one read in flight
module axil_reg_port
(
   input  wire                  sys_clk_in,
   input  wire                  rst_in,
   input  wire [`ADDR_W-1:0]    awaddr_in,
   input  wire                  awvalid_in,
   output wire                  awready_out,
   input  wire [`DATA_W-1:0]    wdata_in,
   input  wire [3:0]            wstrb_in,
   input  wire                  wvalid_in,
   output wire                  wready_out,
   output wire [1:0]            bresp_out,
   output wire                  bvalid_out,
   input  wire                  bready_in,
   input  wire [`ADDR_W-1:0]    araddr_in,
   input  wire                  arvalid_in,
   output wire                  arready_out,
   output wire [`DATA_W-1:0]    rdata_out,
   output wire [1:0]            rresp_out,
   output wire                  rvalid_out,
   input  wire                  rready_in,
   output wire                  wr_do_out,
   output wire [`ADDR_W-1:0]    wr_addr_out,
   output wire [`DATA_W-1:0]    wr_data_out,
   output wire [3:0]            wr_strb_out,
   input  wire                  wr_err_in,
   output wire [`ADDR_W-1:0]    rd_addr_out,
   input  wire [`DATA_W-1:0]    rd_data_in,
   input  wire                  rd_err_in
);

   reg                aw_full_r;
   reg  [`ADDR_W-1:0] aw_addr_r;
   reg                w_full_r;
   reg  [`DATA_W-1:0] w_data_r;
   reg  [3:0]         w_strb_r;
   reg                awready_r;
   reg                wready_r;
   reg                bvalid_r;
   reg  [1:0]         bresp_r;
   reg                arready_r;
   reg                rvalid_r;
   reg  [`DATA_W-1:0] rdata_r;
   reg  [1:0]         rresp_r;

   wire aw_take     = awvalid_in & awready_r;
   wire w_take      = wvalid_in & wready_r;
   wire wr_do       = aw_full_r & w_full_r & ~bvalid_r;
   wire aw_full_nxt = (aw_full_r & ~wr_do) | aw_take;
   wire w_full_nxt  = (w_full_r & ~wr_do) | w_take;
   wire bvalid_nxt  = wr_do | (bvalid_r & ~bready_in);
   wire ar_take     = arvalid_in & arready_r;
   wire rvalid_nxt  = ar_take | (rvalid_r & ~rready_in);

   // Address and data are held apart and joined once both have arrived
   always @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         aw_full_r <= 1'b0;
         aw_addr_r <= {`ADDR_W{1'b0}};
         w_full_r  <= 1'b0;
         w_data_r  <= {`DATA_W{1'b0}};
         w_strb_r  <= 4'h0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= {`DATA_W{1'b0}};
         rresp_r   <= `RESP_OKAY;
      end
      else
      begin
         aw_full_r <= aw_full_nxt;
         w_full_r  <= w_full_nxt;
         awready_r <= ~aw_full_nxt;
         wready_r  <= ~w_full_nxt;
         bvalid_r  <= bvalid_nxt;
         arready_r <= ~rvalid_nxt;
         rvalid_r  <= rvalid_nxt;
         if (aw_take)
            aw_addr_r <= awaddr_in;
         if (w_take)
         begin
            w_data_r <= wdata_in;
            w_strb_r <= wstrb_in;
         end
         if (wr_do)
            bresp_r <= wr_err_in ? `RESP_SLVERR : `RESP_OKAY;
         if (ar_take)
         begin
            rdata_r <= rd_err_in ? {`DATA_W{1'b0}} : rd_data_in;
            rresp_r <= rd_err_in ? `RESP_SLVERR : `RESP_OKAY;
         end
      end
   end

   assign awready_out = awready_r;
   assign wready_out  = wready_r;
   assign bvalid_out  = bvalid_r;
   assign bresp_out   = bresp_r;
   assign arready_out = arready_r;
   assign rvalid_out  = rvalid_r;
   assign rdata_out   = rdata_r;
   assign rresp_out   = rresp_r;
   assign wr_do_out   = wr_do;
   assign wr_addr_out = aw_addr_r;
   assign wr_data_out = w_data_r;
   assign wr_strb_out = w_strb_r;
   assign rd_addr_out = araddr_in;

endmodule // axil_reg_port

/* File: hw/timer_event_gen.v */
`timescale 1ns/100ps
`include "timer_event_map.vh"

// Operation
// - Event request register resets to zero, nothing pending
// - Bit 7 asks for a break event, self-clears; zero does nothing
// - Break request clears output enable, sets break flag, may interrupt
// - Bit 6 asks for a trigger event, self-clears; zero does nothing
// - Trigger request sets trigger flag and may raise interrupt or DMA
// - Trigger flag sets on any trigger event, held until software clears
// - Update flag sets on any update event, held until software clears
// - Channel flag sets on a software compare request, or on an outside compare while channel is in output mode
// - Commutation flag sets on commutation event, cleared only by software
module timer_event_gen
(
   input  wire                  sys_clk_in,
   input  wire                  rst_in,
   input  wire [`ADDR_W-1:0]    s_axi_awaddr_in,
   input  wire                  s_axi_awvalid_in,
   output wire                  s_axi_awready_out,
   input  wire [`DATA_W-1:0]    s_axi_wdata_in,
   input  wire [3:0]            s_axi_wstrb_in,
   input  wire                  s_axi_wvalid_in,
   output wire                  s_axi_wready_out,
   output wire [1:0]            s_axi_bresp_out,
   output wire                  s_axi_bvalid_out,
   input  wire                  s_axi_bready_in,
   input  wire [`ADDR_W-1:0]    s_axi_araddr_in,
   input  wire                  s_axi_arvalid_in,
   output wire                  s_axi_arready_out,
   output wire [`DATA_W-1:0]    s_axi_rdata_out,
   output wire [1:0]            s_axi_rresp_out,
   output wire                  s_axi_rvalid_out,
   input  wire                  s_axi_rready_in,
   input  wire [`EV_W-1:0]      hw_event_in,
   output wire [`EV_W-1:0]      event_pulse_out,
   output wire [`EV_W-1:0]      dma_req_out,
   output wire                  primary_output_enable_out,
   output wire                  irq_out
);

   // Software event request bits, one per event
   reg  [`EV_W-1:0]   software_event_trigger_r;
   reg  [`EV_W-1:0]   software_event_trigger_nxt;

   // Configuration held for software
   reg                primary_output_enable_r;
   reg                primary_output_enable_nxt;
   reg  [`CHAN_W-1:0] chan_output_mode_r;
   reg  [`EV_W-1:0]   dma_enable_r;
   reg  [`EV_W-1:0]   int_enable_r;

   // Registered outputs
   reg  [`EV_W-1:0]   event_pulse_r;
   reg  [`EV_W-1:0]   dma_req_r;
   reg                irq_r;

   // Bus side of the register file
   wire               wr_do;
   wire [`ADDR_W-1:0] wr_addr;
   wire [`DATA_W-1:0] wr_data;
   wire [3:0]         wr_strb;
   wire [`ADDR_W-1:0] rd_addr;
   reg  [`DATA_W-1:0] rd_data;
   reg                rd_err;
   reg                wr_err;

   // Decoded write strobes
   reg                wr_control;
   reg                wr_chan_mode;
   reg                wr_dma_enable;
   reg                wr_int_enable;
   reg                wr_sw_event;
   reg                wr_flag_clear;

   // Event gathering
   wire [`EV_W-1:0]   hw_event_gated;
   wire [`EV_W-1:0]   event_now;
   wire [`EV_W-1:0]   flag_clear;
   wire [`EV_W-1:0]   interrupt_flag_register;
   wire [`EV_W-1:0]   flag_nxt;
   wire               word_write;

   axil_reg_port u_bus
   (
      .sys_clk_in  (sys_clk_in),
      .rst_in      (rst_in),
      .awaddr_in   (s_axi_awaddr_in),
      .awvalid_in  (s_axi_awvalid_in),
      .awready_out (s_axi_awready_out),
      .wdata_in    (s_axi_wdata_in),
      .wstrb_in    (s_axi_wstrb_in),
      .wvalid_in   (s_axi_wvalid_in),
      .wready_out  (s_axi_wready_out),
      .bresp_out   (s_axi_bresp_out),
      .bvalid_out  (s_axi_bvalid_out),
      .bready_in   (s_axi_bready_in),
      .araddr_in   (s_axi_araddr_in),
      .arvalid_in  (s_axi_arvalid_in),
      .arready_out (s_axi_arready_out),
      .rdata_out   (s_axi_rdata_out),
      .rresp_out   (s_axi_rresp_out),
      .rvalid_out  (s_axi_rvalid_out),
      .rready_in   (s_axi_rready_in),
      .wr_do_out   (wr_do),
      .wr_addr_out (wr_addr),
      .wr_data_out (wr_data),
      .wr_strb_out (wr_strb),
      .wr_err_in   (wr_err),
      .rd_addr_out (rd_addr),
      .rd_data_in  (rd_data),
      .rd_err_in   (rd_err)
   );

   // Only whole-word writes change anything; narrower ones are refused
   assign word_write = wr_do & (wr_strb == `STRB_FULL);

   // Write decode and error answer
   always @*
   begin
      wr_control    = 1'b0;
      wr_chan_mode  = 1'b0;
      wr_dma_enable = 1'b0;
      wr_int_enable = 1'b0;
      wr_sw_event   = 1'b0;
      wr_flag_clear = 1'b0;
      wr_err        = 1'b0;
      case ({wr_addr[`ADDR_W-1:2], 2'b00})
         `OFS_CONTROL    : wr_control    = word_write;
         `OFS_CHAN_MODE  : wr_chan_mode  = word_write;
         `OFS_DMA_ENABLE : wr_dma_enable = word_write;
         `OFS_INT_ENABLE : wr_int_enable = word_write;
         `OFS_FLAGS      : wr_err        = 1'b0; // Read-only, write ignored
         `OFS_SW_EVENT   : wr_sw_event   = word_write;
         `OFS_FLAG_CLEAR : wr_flag_clear = word_write;
         default         : wr_err        = 1'b1;
      endcase
      if (wr_strb != `STRB_FULL)
         wr_err = 1'b1;
   end

   // Read mux; write-only registers read as zero
   always @*
   begin
      rd_data = {`DATA_W{1'b0}};
      rd_err  = 1'b0;
      case ({rd_addr[`ADDR_W-1:2], 2'b00})
         `OFS_CONTROL    : rd_data[`CTL_PRIMARY_OUTPUT_ENABLE] = primary_output_enable_r;
         `OFS_CHAN_MODE  : rd_data[`CHAN_W-1:0] = chan_output_mode_r;
         `OFS_DMA_ENABLE : rd_data[`EV_W-1:0] = dma_enable_r;
         `OFS_INT_ENABLE : rd_data[`EV_W-1:0] = int_enable_r;
         `OFS_FLAGS      : rd_data[`EV_W-1:0] = interrupt_flag_register;
         `OFS_SW_EVENT   : rd_data = {`DATA_W{1'b0}};
         `OFS_FLAG_CLEAR : rd_data = {`DATA_W{1'b0}};
         default         : rd_err  = 1'b1;
      endcase
   end

   // Request bits: a one sets, a zero leaves alone, issued next cycle
   // then dropped; bits 31..8 are not stored so they cannot act
   always @*
   begin
      software_event_trigger_nxt = {`EV_W{1'b0}};
      if (wr_sw_event)
         software_event_trigger_nxt = wr_data[`EV_W-1:0];
   end

   // Outside compare events count only for channels in output mode
   assign hw_event_gated[`EV_CH3:`EV_CH0] =
      hw_event_in[`EV_CH3:`EV_CH0] & chan_output_mode_r;
   assign hw_event_gated[`EV_UPDATE] = hw_event_in[`EV_UPDATE];
   assign hw_event_gated[`EV_W-1:`EV_COMMUTATION] =
      hw_event_in[`EV_W-1:`EV_COMMUTATION];

   // Issued events: pending software requests plus outside events
   assign event_now = software_event_trigger_r | hw_event_gated;

   // Flag clear: a one in the clear word drops that flag
   assign flag_clear = wr_flag_clear ? wr_data[`EV_W-1:0]
                                     : {`EV_W{1'b0}};

   event_flag_bank u_flags
   (
      .sys_clk_in   (sys_clk_in),
      .rst_in       (rst_in),
      .set_in       (event_now),
      .clear_in     (flag_clear),
      .flag_out     (interrupt_flag_register),
      .flag_nxt_out (flag_nxt)
   );

   // Output enable: software sets or clears, a break always wins
   always @*
   begin
      primary_output_enable_nxt = primary_output_enable_r;
      if (wr_control)
         primary_output_enable_nxt = wr_data[`CTL_PRIMARY_OUTPUT_ENABLE];
      if (event_now[`EV_BREAK])
         primary_output_enable_nxt = 1'b0;
   end

   // Request register and configuration registers
   always @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         software_event_trigger_r <= `RST_SW_EVENT;
         primary_output_enable_r  <= `RST_PRIMARY_OUTPUT_ENABLE;
         chan_output_mode_r       <= `RST_CHAN_MODE;
         dma_enable_r             <= `RST_ENABLES;
         int_enable_r             <= `RST_ENABLES;
      end
      else
      begin
         software_event_trigger_r <= software_event_trigger_nxt;
         primary_output_enable_r  <= primary_output_enable_nxt;
         if (wr_chan_mode)
            chan_output_mode_r <= wr_data[`CHAN_W-1:0];
         if (wr_dma_enable)
            dma_enable_r <= wr_data[`EV_W-1:0];
         if (wr_int_enable)
            int_enable_r <= wr_data[`EV_W-1:0];
      end
   end

   // Event pulses, DMA requests and interrupt level, all registered
   always @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         event_pulse_r <= {`EV_W{1'b0}};
         dma_req_r     <= {`EV_W{1'b0}};
         irq_r         <= 1'b0;
      end
      else
      begin
         event_pulse_r <= event_now;
         dma_req_r     <= event_now & dma_enable_r;
         irq_r         <= |(flag_nxt & int_enable_r);
      end
   end

   assign event_pulse_out           = event_pulse_r;
   assign dma_req_out               = dma_req_r;
   assign primary_output_enable_out = primary_output_enable_r;
   assign irq_out                   = irq_r;

endmodule // timer_event_gen

/* File: tb/timer_event_gen_asserts.sv */
`timescale 1ns/100ps
`include "timer_event_map.vh"

// Port-level checks of the event request block
module timer_event_gen_asserts
(
   input wire        sys_clk_in,
   input wire        rst_in,
   input wire [7:0]  s_axi_awaddr_in,
   input wire        s_axi_awvalid_in,
   input wire        s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0]  s_axi_wstrb_in,
   input wire        s_axi_wvalid_in,
   input wire        s_axi_wready_out,
   input wire [1:0]  s_axi_bresp_out,
   input wire        s_axi_bvalid_out,
   input wire        s_axi_bready_in,
   input wire [7:0]  s_axi_araddr_in,
   input wire        s_axi_arvalid_in,
   input wire        s_axi_arready_out,
   input wire [31:0] s_axi_rdata_out,
   input wire [1:0]  s_axi_rresp_out,
   input wire        s_axi_rvalid_out,
   input wire [7:0]  event_pulse_out,
   input wire [7:0]  dma_req_out,
   input wire        primary_output_enable_out,
   input wire        irq_out
);
   reg  [7:0] aw_q_r;
   reg  [7:0] ar_q_r;
   reg  [7:0] wd_q_r;
   reg  [3:0] ws_q_r;
   wire       bad_w;
   wire       sw_ok;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   // Remember the payload of the last accepted write and read
   always @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         aw_q_r <= 8'h00;
         ar_q_r <= 8'h00;
         wd_q_r <= 8'h00;
         ws_q_r <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid_in && s_axi_awready_out)
            aw_q_r <= s_axi_awaddr_in;
         if (s_axi_arvalid_in && s_axi_arready_out)
            ar_q_r <= s_axi_araddr_in;
         if (s_axi_wvalid_in && s_axi_wready_out)
         begin
            wd_q_r <= s_axi_wdata_in[7:0];
            ws_q_r <= s_axi_wstrb_in;
         end
      end
   end

   // Refused writes: partial word or beyond the map; low address bits ignored
   assign bad_w = ws_q_r != 4'hF || aw_q_r > 8'h1B;
   assign sw_ok = !bad_w && aw_q_r == `OFS_SW_EVENT;

   a_reset_quiet: assert property ($fell(rst_in) |->
      event_pulse_out == 8'h00 && !s_axi_bvalid_out && !irq_out)
      else $error("outputs active right after reset");
   a_write_resp: assert property ($rose(s_axi_bvalid_out) |->
      s_axi_bresp_out == (bad_w ? `RESP_SLVERR : `RESP_OKAY))
      else $error("write response code wrong");
   a_resp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped early");
   a_request_fires: assert property ($rose(s_axi_bvalid_out) && sw_ok
      |-> ##[0:3] (event_pulse_out & wd_q_r) == wd_q_r)
      else $error("requested event not issued");
   a_request_clears: assert property ($rose(s_axi_bvalid_out) && sw_ok
      |-> ##4 (event_pulse_out & wd_q_r) == 8'h00)
      else $error("request bit did not clear");
   a_break_drops_primary_output_enable: assert property (event_pulse_out[`EV_BREAK]
      |-> !primary_output_enable_out)
      else $error("output enable kept during break");
   a_dma_needs_event: assert property (
      (dma_req_out & ~event_pulse_out) == 8'h00)
      else $error("dma request without event");
   a_sw_reads_zero: assert property ($rose(s_axi_rvalid_out) &&
      ar_q_r == `OFS_SW_EVENT |-> s_axi_rdata_out == 32'h0 &&
      s_axi_rresp_out == `RESP_OKAY)
      else $error("request register read not zero");
endmodule // timer_event_gen_asserts

bind timer_event_gen timer_event_gen_asserts timer_event_gen_asserts_inst (.*);

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`include "timer_event_map.vh"

// Register-level test of the event request block
module testbench;
   reg         sys_clk_in = 1'b0;
   reg         rst_in = 1'b1;
   reg  [7:0]  s_axi_awaddr_in = 8'h00;
   reg         s_axi_awvalid_in = 1'b0;
   reg  [31:0] s_axi_wdata_in = 32'h0;
   reg  [3:0]  s_axi_wstrb_in = 4'h0;
   reg         s_axi_wvalid_in = 1'b0;
   reg         s_axi_bready_in = 1'b0;
   reg  [7:0]  s_axi_araddr_in = 8'h00;
   reg         s_axi_arvalid_in = 1'b0;
   reg         s_axi_rready_in = 1'b0;
   reg  [7:0]  hw_event_in = 8'h00;
   wire        s_axi_awready_out;
   wire        s_axi_wready_out;
   wire [1:0]  s_axi_bresp_out;
   wire        s_axi_bvalid_out;
   wire        s_axi_arready_out;
   wire [31:0] s_axi_rdata_out;
   wire [1:0]  s_axi_rresp_out;
   wire        s_axi_rvalid_out;
   wire [7:0]  event_pulse_out;
   wire [7:0]  dma_req_out;
   wire        primary_output_enable_out;
   wire        irq_out;
   integer     err_count = 0;
   integer     samples_checked = 0;
   integer     cycles = 0;
   integer     k;
   integer     n;
   reg  [31:0] pls;
   reg  [31:0] dmq;

   timer_event_gen timer_event_gen_inst (.*);

   always #2.5 sys_clk_in = ~sys_clk_in;

   task check(input [31:0] seen, input [31:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask

   // Full AXI write; address and data offered together
   task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
   begin
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_wstrb_in <= s;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      @(posedge sys_clk_in);
      while (s_axi_awvalid_in || s_axi_wvalid_in || s_axi_bready_in)
      begin
         if (s_axi_awvalid_in && s_axi_awready_out)
            s_axi_awvalid_in <= 1'b0;
         if (s_axi_wvalid_in && s_axi_wready_out)
            s_axi_wvalid_in <= 1'b0;
         if (s_axi_bready_in && s_axi_bvalid_out)
         begin
            s_axi_bready_in <= 1'b0;
            check({30'h0, s_axi_bresp_out}, {30'h0, r});
         end
         @(posedge sys_clk_in);
      end
   end
   endtask

   // Full AXI read, compared with expected data and response
   task rd_chk(input [7:0] a, input [31:0] e, input [1:0] r);
   begin
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      @(posedge sys_clk_in);
      while (s_axi_arvalid_in || s_axi_rready_in)
      begin
         if (s_axi_arvalid_in && s_axi_arready_out)
            s_axi_arvalid_in <= 1'b0;
         if (s_axi_rready_in && s_axi_rvalid_out)
         begin
            s_axi_rready_in <= 1'b0;
            check(s_axi_rdata_out, e);
            check({30'h0, s_axi_rresp_out}, {30'h0, r});
         end
         @(posedge sys_clk_in);
      end
   end
   endtask

   // Poll from this edge on for the first event pulse
   task wait_pulse;
   begin
      pls = {24'h0, event_pulse_out};
      dmq = {24'h0, dma_req_out};
      for (n = 0; n < 8 && pls == 32'h0; n = n + 1)
      begin
         @(posedge sys_clk_in);
         pls = {24'h0, event_pulse_out};
         dmq = {24'h0, dma_req_out};
      end
   end
   endtask

   // One-cycle outside event pulse
   task hw_pulse(input [7:0] v);
   begin
      hw_event_in <= v;
      @(posedge sys_clk_in);
      hw_event_in <= 8'h00;
      wait_pulse;
   end
   endtask

   task finish_test;
   begin
      $display("checks=%0d errors=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask

   // Hang guard
   always @(posedge sys_clk_in)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         err_count = err_count + 1;
         finish_test;
      end
   end

   initial
   begin
      repeat (12) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      rd_chk(`OFS_SW_EVENT, 32'h0, `RESP_OKAY);
      rd_chk(`OFS_FLAGS, 32'h0, `RESP_OKAY);
      wr(`OFS_CHAN_MODE, 32'hF, `STRB_FULL, `RESP_OKAY);
      wr(`OFS_DMA_ENABLE, 32'hFF, `STRB_FULL, `RESP_OKAY);
      wr(`OFS_INT_ENABLE, 32'hFF, `STRB_FULL, `RESP_OKAY);
      // Each request bit alone: pulse, dma, flag, irq, clear
      for (k = 0; k < 8; k = k + 1)
      begin
         wr(`OFS_CONTROL, 32'h1, `STRB_FULL, `RESP_OKAY);
         wr(`OFS_SW_EVENT, 32'h1 << k, `STRB_FULL, `RESP_OKAY);
         wait_pulse;
         check(pls, 32'h1 << k);
         check(dmq, 32'h1 << k);
         @(posedge sys_clk_in);
         check({24'h0, event_pulse_out}, 32'h0);
         check({31'h0, primary_output_enable_out}, k != 7);
         check({31'h0, irq_out}, 32'h1);
         rd_chk(`OFS_FLAGS, 32'h1 << k, `RESP_OKAY);
         wr(`OFS_FLAG_CLEAR, 32'h1 << k, `STRB_FULL, `RESP_OKAY);
         check({31'h0, irq_out}, 32'h0);
      end
      // Zero write and partial word issue nothing
      wr(`OFS_SW_EVENT, 32'h0, `STRB_FULL, `RESP_OKAY);
      wait_pulse;
      check(pls, 32'h0);
      wr(`OFS_SW_EVENT, 32'h40, 4'h3, `RESP_SLVERR);
      wait_pulse;
      check(pls, 32'h0);
      wr(8'h40, 32'h1, `STRB_FULL, `RESP_SLVERR);
      rd_chk(8'h40, 32'h0, `RESP_SLVERR);
      // Masked trigger: flag only, then unmask
      wr(`OFS_INT_ENABLE, 32'h0, `STRB_FULL, `RESP_OKAY);
      wr(`OFS_DMA_ENABLE, 32'h0, `STRB_FULL, `RESP_OKAY);
      wr(`OFS_SW_EVENT, 32'h40, `STRB_FULL, `RESP_OKAY);
      wait_pulse;
      check(dmq, 32'h0);
      check({31'h0, irq_out}, 32'h0);
      rd_chk(`OFS_FLAGS, 32'h40, `RESP_OKAY);
      wr(`OFS_INT_ENABLE, 32'h40, `STRB_FULL, `RESP_OKAY);
      check({31'h0, irq_out}, 32'h1);
      wr(`OFS_FLAG_CLEAR, 32'h40, `STRB_FULL, `RESP_OKAY);
      // Outside compares ignored while channels are not outputs
      wr(`OFS_CHAN_MODE, 32'h0, `STRB_FULL, `RESP_OKAY);
      hw_pulse(8'h1E);
      rd_chk(`OFS_FLAGS, 32'h0, `RESP_OKAY);
      wr(`OFS_CHAN_MODE, 32'hF, `STRB_FULL, `RESP_OKAY);
      hw_pulse(8'h63);
      rd_chk(`OFS_FLAGS, 32'h63, `RESP_OKAY);
      finish_test;
   end
endmodule // testbench
